// file: src/sad_cfg.svh
`ifndef SAD_CFG_SVH
`define SAD_CFG_SVH

// Segment register codes as carried on the decoder outputs.
`define SAD_SEG_ES       3'h0
`define SAD_SEG_CS       3'h1
`define SAD_SEG_SS       3'h2
`define SAD_SEG_DS       3'h3
`define SAD_SEG_FS       3'h4
`define SAD_SEG_GS       3'h5

// Index multipliers.
`define SAD_SCALE_X1     4'h1
`define SAD_SCALE_X2     4'h2
`define SAD_SCALE_X4     4'h4
`define SAD_SCALE_X8     4'h8

// Scale codes.
`define SAD_SS_X1        2'h0
`define SAD_SS_X2        2'h1
`define SAD_SS_X4        2'h2
`define SAD_SS_X8        2'h3

// Displacement classes in the addressing byte.
`define SAD_MOD_NODISP   2'h0
`define SAD_MOD_SHORT    2'h1
`define SAD_MOD_LONG     2'h2
`define SAD_MOD_REG      2'h3

// Special register field codes.
`define SAD_IDX_NONE     3'h4
`define SAD_BASE_ESP     3'h4
`define SAD_BASE_EBP     3'h5
`define SAD_WIDE_FIRST_UNDEF 3'h6

// Field positions.
`define SAD_MOD_HI       7
`define SAD_MOD_LO       6
`define SAD_SS_HI        7
`define SAD_SS_LO        6
`define SAD_IDX_HI       5
`define SAD_IDX_LO       3
`define SAD_BASE_HI      2
`define SAD_BASE_LO      0

`endif

// file: src/sad_pkg.sv
`default_nettype none

package sad_pkg;
    typedef logic [2:0] sad_seg_t;
    typedef logic [2:0] sad_reg_t;
    typedef logic [3:0] sad_scale_t;
    typedef enum logic [1:0] {
        sad_disp_none,
        sad_disp_short_offset,
        sad_disp_long_offset
    } sad_disp_t;
endpackage : sad_pkg

`default_nettype wire

// file: src/sad_sib_if.sv
`default_nettype none

interface sad_sib_if;
    logic [1:0]         disp_class;
    logic [7:0]         sib;
    logic               base_en;
    sad_pkg::sad_reg_t  base_reg;
    logic               index_en;
    sad_pkg::sad_reg_t  index_reg;
    sad_pkg::sad_scale_t scale;
    sad_pkg::sad_disp_t disp;
    sad_pkg::sad_seg_t  seg;
    logic               undef;

    modport dec (
        input  disp_class,
        input  sib,
        output base_en,
        output base_reg,
        output index_en,
        output index_reg,
        output scale,
        output disp,
        output seg,
        output undef
    );

    modport user (
        output disp_class,
        output sib,
        input  base_en,
        input  base_reg,
        input  index_en,
        input  index_reg,
        input  scale,
        input  disp,
        input  seg,
        input  undef
    );
endinterface : sad_sib_if

`default_nettype wire

// file: src/sad_sib_dec.sv
`include "sad_cfg.svh"
`default_nettype none

module sad_sib_dec (
    sad_sib_if.dec  sib_if
);
    logic [1:0] ss;
    logic [2:0] idx;
    logic [2:0] base;

    assign ss   = sib_if.sib[`SAD_SS_HI:`SAD_SS_LO];
    assign idx  = sib_if.sib[`SAD_IDX_HI:`SAD_IDX_LO];
    assign base = sib_if.sib[`SAD_BASE_HI:`SAD_BASE_LO];

    always_comb begin
        unique case (ss)
            `SAD_SS_X1: sib_if.scale = `SAD_SCALE_X1;
            `SAD_SS_X2: sib_if.scale = `SAD_SCALE_X2;
            `SAD_SS_X4: sib_if.scale = `SAD_SCALE_X4;
            `SAD_SS_X8: sib_if.scale = `SAD_SCALE_X8;
        endcase
    end

    // The no-index code drops the index term entirely.
    assign sib_if.index_en  = (idx != `SAD_IDX_NONE);
    assign sib_if.index_reg = idx;

    // A scaled no-index operand is flagged rather than guessed at.
    assign sib_if.undef = ((idx == `SAD_IDX_NONE) && (ss != `SAD_SS_X1))
                          || (sib_if.disp_class == `SAD_MOD_REG);

    always_comb begin
        sib_if.base_reg = base;
        sib_if.base_en  = 1'b1;
        sib_if.disp     = sad_pkg::sad_disp_none;
        unique case (sib_if.disp_class)
            `SAD_MOD_NODISP: begin
                if (base == `SAD_BASE_EBP) begin
                    sib_if.base_en = 1'b0;
                    sib_if.disp    = sad_pkg::sad_disp_long_offset;
                end
            end
            `SAD_MOD_SHORT: sib_if.disp = sad_pkg::sad_disp_short_offset;
            `SAD_MOD_LONG:  sib_if.disp = sad_pkg::sad_disp_long_offset;
            `SAD_MOD_REG:   sib_if.base_en = 1'b0;
        endcase
    end

    // Stack-based addresses default to the stack segment.
    assign sib_if.seg = ((base == `SAD_BASE_ESP) ||
                         ((base == `SAD_BASE_EBP) && (sib_if.disp_class != `SAD_MOD_NODISP)))
                        ? `SAD_SEG_SS : `SAD_SEG_DS;
endmodule : sad_sib_dec

`default_nettype wire

// file: src/sad_decode.sv
`include "sad_cfg.svh"
`default_nettype none

module sad_decode (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                clk_en_i,
    input  wire logic                req_valid_i,
    input  wire logic                seg_wide_sel_i,
    input  wire logic [2:0]          seg_field_i,
    input  wire logic [7:0]          modrm_i,
    input  wire logic [7:0]          sib_i,
    output var  logic                ack_valid_o,
    output var  sad_pkg::sad_seg_t   seg_sel_o,
    output var  logic                seg_undef_o,
    output var  sad_pkg::sad_seg_t   ea_seg_o,
    output var  logic                base_en_o,
    output var  sad_pkg::sad_reg_t   base_reg_o,
    output var  logic                index_en_o,
    output var  sad_pkg::sad_reg_t   index_reg_o,
    output var  sad_pkg::sad_scale_t scale_o,
    output var  sad_pkg::sad_disp_t  disp_o,
    output var  logic                ea_undef_o
);

    function automatic sad_pkg::sad_seg_t seg_narrow(input logic [1:0] code);
        unique case (code)
            2'h0: seg_narrow = `SAD_SEG_ES;
            2'h1: seg_narrow = `SAD_SEG_CS;
            2'h2: seg_narrow = `SAD_SEG_SS;
            2'h3: seg_narrow = `SAD_SEG_DS;
        endcase
    endfunction : seg_narrow

    // The wide form reuses the narrow table so the first four codes cannot drift apart.
    function automatic sad_pkg::sad_seg_t seg_wide(input logic [2:0] code);
        unique case (code[2:1])
            2'h0,
            2'h1:    seg_wide = seg_narrow(code[1:0]);
            2'h2:    seg_wide = code[0] ? `SAD_SEG_GS : `SAD_SEG_FS;
            default: seg_wide = `SAD_SEG_ES;
        endcase
    endfunction : seg_wide

    function automatic logic wide_undef(input logic [2:0] code);
        wide_undef = (code >= `SAD_WIDE_FIRST_UNDEF);
    endfunction : wide_undef

    sad_sib_if sib_bus ();

    assign sib_bus.disp_class = modrm_i[`SAD_MOD_HI:`SAD_MOD_LO];
    assign sib_bus.sib        = sib_i;

    sad_sib_dec u_sib_dec (
        .sib_if (sib_bus)
    );

    sad_pkg::sad_seg_t next_seg;
    logic              next_seg_undef;
    logic              take;

    assign take = clk_en_i && req_valid_i;

    always_comb begin
        if (seg_wide_sel_i) begin
            next_seg       = seg_wide(seg_field_i);
            next_seg_undef = wide_undef(seg_field_i);
        end else begin
            next_seg       = seg_narrow(seg_field_i[1:0]);
            next_seg_undef = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            ack_valid_o <= req_valid_i;
        end
    end

    // Segment result is held between requests so the address unit may sample late.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seg_sel_o   <= `SAD_SEG_ES;
            seg_undef_o <= 1'b0;
        end else if (take) begin
            seg_sel_o   <= next_seg;
            seg_undef_o <= next_seg_undef;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ea_seg_o    <= `SAD_SEG_DS;
            base_en_o   <= 1'b0;
            base_reg_o  <= 3'h0;
            index_en_o  <= 1'b0;
            index_reg_o <= 3'h0;
            scale_o     <= `SAD_SCALE_X1;
            disp_o      <= sad_pkg::sad_disp_none;
            ea_undef_o  <= 1'b0;
        end else if (take) begin
            ea_seg_o    <= sib_bus.seg;
            base_en_o   <= sib_bus.base_en;
            base_reg_o  <= sib_bus.base_reg;
            index_en_o  <= sib_bus.index_en;
            index_reg_o <= sib_bus.index_reg;
            scale_o     <= sib_bus.scale;
            disp_o      <= sib_bus.disp;
            ea_undef_o  <= sib_bus.undef;
        end
    end

    // Helper views of the sampled request fields for the checks below.
    logic [1:0] in_mod;
    logic [1:0] in_ss;
    logic [2:0] in_idx;
    logic [2:0] in_base;

    assign in_mod  = modrm_i[`SAD_MOD_HI:`SAD_MOD_LO];
    assign in_ss   = sib_i[`SAD_SS_HI:`SAD_SS_LO];
    assign in_idx  = sib_i[`SAD_IDX_HI:`SAD_IDX_LO];
    assign in_base = sib_i[`SAD_BASE_HI:`SAD_BASE_LO];

    // Reference table for the checks, kept apart from the decode functions so that a slip in
    // those functions cannot hide behind itself.
    function automatic sad_pkg::sad_seg_t ref_seg(input logic [2:0] code);
        unique case (code)
            3'h0:    ref_seg = `SAD_SEG_ES;
            3'h1:    ref_seg = `SAD_SEG_CS;
            3'h2:    ref_seg = `SAD_SEG_SS;
            3'h3:    ref_seg = `SAD_SEG_DS;
            3'h4:    ref_seg = `SAD_SEG_FS;
            3'h5:    ref_seg = `SAD_SEG_GS;
            default: ref_seg = `SAD_SEG_ES;
        endcase
    endfunction : ref_seg

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    AST_NARROW_SEG: assert property (
        $past(take) && !$past(seg_wide_sel_i)
        |-> seg_sel_o == ref_seg({1'h0, $past(seg_field_i[1:0])}) && !seg_undef_o
    ) else $error("Narrow segment selector decoded wrongly.");

    AST_WIDE_SEG: assert property (
        $past(take) && $past(seg_wide_sel_i) && $past(seg_field_i) < 3'h6
        |-> !seg_undef_o && seg_sel_o == ref_seg($past(seg_field_i))
    ) else $error("Wide segment selector decoded wrongly.");

    AST_WIDE_UNDEF: assert property (
        $past(take) && $past(seg_wide_sel_i) && $past(seg_field_i) >= 3'h6 |-> seg_undef_o
    ) else $error("Undefined wide segment code not flagged.");

    AST_SCALE: assert property (
        $past(take) && $past(in_ss) != 2'h2 |-> scale_o == (4'h1 << $past(in_ss))
    ) else $error("Scale multiplier wrong.");

    AST_SCALE_X4: assert property (
        take && in_ss == 2'h2 |=> scale_o == 4'h4
    ) else $error("Scale code 10 did not give four.");

    AST_INDEX: assert property (
        $past(take) |-> index_en_o == ($past(in_idx) != 3'h4) && index_reg_o == $past(in_idx)
    ) else $error("Index selection wrong.");

    AST_EA_UNDEF: assert property (
        take && in_idx == 3'h4 && in_ss != 2'h0 |=> ea_undef_o
    ) else $error("Scaled no-index operand not flagged.");

    AST_BASE_FIELD: assert property (
        $past(take) && $past(in_mod) != 2'h3 |-> base_reg_o == $past(in_base)
    ) else $error("Base field not passed through.");

    AST_NODISP_LONG: assert property (
        take && in_mod == 2'h0 && in_base == 3'h5
        |=> !base_en_o && disp_o == sad_pkg::sad_disp_long_offset && ea_seg_o == `SAD_SEG_DS
    ) else $error("Class 00 base 101 must use a long offset without base.");

    AST_DISP_SEG: assert property (
        take && in_mod inside {2'h1, 2'h2}
        |=> base_en_o
            && disp_o == (($past(in_mod) == 2'h1) ? sad_pkg::sad_disp_short_offset
                                                  : sad_pkg::sad_disp_long_offset)
            && ea_seg_o == (($past(in_base) inside {3'h4, 3'h5}) ? `SAD_SEG_SS : `SAD_SEG_DS)
    ) else $error("Offset class or segment wrong.");

    AST_NODISP_BASE: assert property (
        take && in_mod == 2'h0 && in_base != 3'h5
        |=> base_en_o && disp_o == sad_pkg::sad_disp_none
            && ea_seg_o == (($past(in_base) == 3'h4) ? `SAD_SEG_SS : `SAD_SEG_DS)
    ) else $error("Class 00 must use the base register without an offset.");

    AST_CLASS_REG: assert property (
        take && in_mod == 2'h3
        |=> ea_undef_o && !base_en_o && disp_o == sad_pkg::sad_disp_none
    ) else $error("Register form not flagged as a non-memory operand.");

    AST_NO_INDEX: assert property (
        take && in_idx == 3'h4 && in_ss == 2'h0 && in_mod != 2'h3
        |=> !index_en_o && !ea_undef_o
    ) else $error("Unscaled no-index operand decoded wrongly.");

    AST_ACK: assert property (
        clk_en_i |=> ack_valid_o == $past(req_valid_i)
    ) else $error("Acknowledge does not follow the request.");

    AST_HOLD: assert property (
        !take |=> $stable(seg_sel_o) && $stable(ea_seg_o) && $stable(base_reg_o)
            && $stable(index_reg_o) && $stable(disp_o)
    ) else $error("Results changed without a taken request.");

    AST_FREEZE: assert property (
        !clk_en_i |=> $stable(ack_valid_o) && $stable(seg_sel_o) && $stable(scale_o)
    ) else $error("State changed while clock enable was low.");

    COV_WIDE_GS: cover property (take && seg_wide_sel_i && seg_field_i == 3'h5);
    COV_SHORT_EBP: cover property (take && in_mod == 2'h1 && in_base == 3'h5);
    COV_LONG_NOBASE: cover property (take && in_mod == 2'h0 && in_base == 3'h5 ##1 take);
    COV_NO_INDEX: cover property (take && in_idx == 3'h4 && in_ss == 2'h0);

endmodule : sad_decode

`default_nettype wire

// file: test/sad_fetch_model.sv
`default_nettype none

module sad_fetch_model (
    input  wire logic       break_rule_i,
    input  wire logic [7:0] sib_in_i,
    output logic      [7:0] sib_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // A well behaved source clears the scale code when no index is encoded.
    // Only a deliberate fault command lets a non-zero scale through.
    assign sib_o = (!break_rule_i && sib_in_i[5:3] == 3'h4) ? {2'h0, sib_in_i[5:0]}
                                                            : sib_in_i;
endmodule : sad_fetch_model

`default_nettype wire

// file: test/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic        w;
        logic [2:0]  f;
        logic [7:0]  m;
        logic [7:0]  s;
        logic [3:0]  sg;
        logic [17:0] ea;
    } sad_row_t;

    logic                clk_i = 1'b0;
    logic                sys_rst_i = 1'b1;
    logic                clk_en_i = 1'b1;
    logic                req_valid_i = 1'b0;
    logic                seg_wide_sel_i = 1'b0;
    logic [2:0]          seg_field_i = 3'h0;
    logic [7:0]          modrm_i = 8'h00;
    logic [7:0]          sib_raw = 8'h00;
    logic                break_rule = 1'b0;
    logic [7:0]          sib_i;
    logic                ack_valid_o;
    sad_pkg::sad_seg_t   seg_sel_o;
    logic                seg_undef_o;
    sad_pkg::sad_seg_t   ea_seg_o;
    logic                base_en_o;
    sad_pkg::sad_reg_t   base_reg_o;
    logic                index_en_o;
    sad_pkg::sad_reg_t   index_reg_o;
    sad_pkg::sad_scale_t scale_o;
    sad_pkg::sad_disp_t  disp_o;
    logic                ea_undef_o;
    int                  fail_count = 0;
    int                  num_checks = 0;
    int                  cycles = 0;
    sad_row_t            rows [13];

    always #2.5 clk_i = ~clk_i;

    sad_fetch_model i_model (.break_rule_i(break_rule), .sib_in_i(sib_raw), .sib_o(sib_i));

    sad_decode i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
        .seg_wide_sel_i(seg_wide_sel_i), .seg_field_i(seg_field_i), .modrm_i(modrm_i),
        .sib_i(sib_i), .ack_valid_o(ack_valid_o), .seg_sel_o(seg_sel_o),
        .seg_undef_o(seg_undef_o), .ea_seg_o(ea_seg_o), .base_en_o(base_en_o),
        .base_reg_o(base_reg_o), .index_en_o(index_en_o), .index_reg_o(index_reg_o),
        .scale_o(scale_o), .disp_o(disp_o), .ea_undef_o(ea_undef_o)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic chk_ea(input logic [17:0] exp);
        chk(22'({ea_seg_o, base_en_o, base_reg_o, index_en_o, index_reg_o, scale_o, disp_o,
                 ea_undef_o}), 22'(exp));
    endtask : chk_ea

    task automatic chk_row(input sad_row_t r);
        // The segment code is meaningless for undefined wide codes, so only the flag is judged.
        if (r.sg[3]) begin
            chk(22'(seg_undef_o), 22'h1);
        end else begin
            chk(22'({seg_undef_o, seg_sel_o}), 22'(r.sg));
        end
        chk_ea(r.ea);
    endtask : chk_row

    task automatic apply(input sad_row_t r);
        req_valid_i <= 1'b1;
        seg_wide_sel_i <= r.w;
        seg_field_i <= r.f;
        modrm_i <= r.m;
        sib_raw <= r.s;
    endtask : apply

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 400) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        rows[0] = '{1'h0, 3'h0, 8'h00, 8'h00, 4'h0, {3'h3,1'h1,3'h0,1'h1,3'h0,4'h1,2'h0,1'h0}};
        rows[1] = '{1'h0, 3'h5, 8'h40, 8'h4C, 4'h1, {3'h2,1'h1,3'h4,1'h1,3'h1,4'h2,2'h1,1'h0}};
        rows[2] = '{1'h0, 3'h2, 8'h80, 8'hBD, 4'h2, {3'h2,1'h1,3'h5,1'h1,3'h7,4'h4,2'h2,1'h0}};
        rows[3] = '{1'h0, 3'h3, 8'h00, 8'h25, 4'h3, {3'h3,1'h0,3'h5,1'h0,3'h4,4'h1,2'h2,1'h0}};
        rows[4] = '{1'h1, 3'h4, 8'h40, 8'h35, 4'h4, {3'h2,1'h1,3'h5,1'h1,3'h6,4'h1,2'h1,1'h0}};
        rows[5] = '{1'h1, 3'h5, 8'h00, 8'hF3, 4'h5, {3'h3,1'h1,3'h3,1'h1,3'h6,4'h8,2'h0,1'h0}};
        rows[6] = '{1'h1, 3'h6, 8'h00, 8'h54, 4'h8, {3'h2,1'h1,3'h4,1'h1,3'h2,4'h2,2'h0,1'h0}};
        rows[7] = '{1'h1, 3'h7, 8'h80, 8'h86, 4'h8, {3'h3,1'h1,3'h6,1'h1,3'h0,4'h4,2'h2,1'h0}};
        for (int i = 8; i < 11; i++) begin
            rows[i] = '{1'h1, 3'(i - 8), 8'h00, 8'h00, 4'(i - 8), rows[0].ea};
        end
        rows[11] = '{1'h1, 3'h3, 8'h40, 8'h0F, 4'h3, {3'h3,1'h1,3'h7,1'h1,3'h1,4'h1,2'h1,1'h0}};
        rows[12] = '{1'h0, 3'h1, 8'hC0, 8'h9A, 4'h1, {3'h3,1'h0,3'h2,1'h1,3'h3,4'h4,2'h0,1'h1}};
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk(22'({ack_valid_o, seg_undef_o, seg_sel_o}), 22'h0);
        chk_ea({3'h3, 1'h0, 3'h0, 1'h0, 3'h0, 4'h1, 2'h0, 1'h0});
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            apply(rows[i]);
            @(negedge clk_i);
            if (i > 0) begin
                chk(22'(ack_valid_o), 22'h1);
                chk_row(rows[i - 1]);
            end
        end
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(negedge clk_i);
        chk_row(rows[11]);
        $display("test table done");
        @(negedge clk_i);
        chk(22'(ack_valid_o), 22'h0);
        chk_ea(rows[11].ea);
        @(posedge clk_i);
        clk_en_i <= 1'b0;
        apply(rows[2]);
        repeat (2) @(negedge clk_i);
        chk(22'(ack_valid_o), 22'h0);
        chk_row(rows[11]);
        $display("test hold done");
        @(posedge clk_i);
        clk_en_i <= 1'b1;
        modrm_i <= 8'h00;
        sib_raw <= 8'hE5;
        break_rule <= 1'b1;
        @(posedge clk_i);
        break_rule <= 1'b0;
        @(negedge clk_i);
        chk(22'(ea_undef_o), 22'h1);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(negedge clk_i);
        chk_ea(rows[3].ea);
        $display("test source fault done");
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(negedge clk_i);
        chk(22'({ack_valid_o, seg_undef_o, seg_sel_o}), 22'h0);
        chk_ea({3'h3, 1'h0, 3'h0, 1'h0, 3'h0, 4'h1, 2'h0, 1'h0});
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        apply(rows[12]);
        repeat (2) @(negedge clk_i);
        chk(22'(ack_valid_o), 22'h1);
        chk_row(rows[12]);
        $display("test reset again done");
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
